//--- hw/flash_self_prog_pkg.sv
package flash_self_prog_pkg;
   localparam logic [2:0] ADDR_CTRL = 3'h0;
   localparam logic [2:0] ADDR_EXT = 3'h1;
   localparam logic [2:0] ADDR_LOCK = 3'h2;
   localparam logic [2:0] ADDR_STATUS = 3'h3;
   localparam int BIT_IRQ_EN = 7;
   localparam int BIT_BUSY = 6;
   localparam int BIT_RD_EN = 4;
   localparam int BIT_LOCK = 3;
   localparam int BIT_PWR = 2;
   localparam int BIT_PER = 1;
   localparam int BIT_SEN = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [4:0] PAT_RD_EN = 5'h11;
   localparam logic [4:0] PAT_LOCK = 5'h09;
   localparam logic [4:0] PAT_PWR = 5'h05;
   localparam logic [4:0] PAT_PER = 5'h03;
   localparam logic [4:0] PAT_STORE = 5'h01;
   localparam logic [2:0] STORE_WINDOW = 3'h4;
   localparam logic [2:0] LOAD_WINDOW = 3'h3;
   localparam logic [15:0] APP_RESET_VECTOR = 16'h0000;
   localparam int WORD_BITS = 7;
   localparam int PAGE_WORDS = 128;
   localparam logic [7:0] LOCK_RESET = 8'hff;
   typedef enum logic [1:0] {
      OP_NONE,
      OP_ERASE,
      OP_WRITE,
      OP_LOCK
   } flash_op_e;
   typedef struct packed {
      logic [1:0] op;
      logic [16:0] page_addr;
      logic no_read_while_write_section;
      logic [7:0] lock_data;
   } flash_req_s;
endpackage : flash_self_prog_pkg

//--- hw/flash_self_prog_control.sv
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/10ps
module flash_self_prog_control
   import flash_self_prog_pkg::*;
#(
   parameter logic [16:0] BOOT_START = 17'h1e000, // Boot loader start word address.
   parameter logic [16:0] NO_READ_WHILE_WRITE_SECTION_START = 17'h1e000, // First word of no-read-while-write area.
   parameter bit HAS_EXT = 1'b1 // Program space above 64K bytes.
) (
   input wire logic i_core_clk, // Core clock, 25 MHz.
   input wire logic i_rstn, // Asynchronous reset, active low.
   input wire logic [2:0] i_addr, // Register address.
   input wire logic [7:0] i_wdata, // Register write data.
   input wire logic i_wr, // Register write strobe.
   input wire logic i_rd, // Register read strobe.
   output logic [7:0] o_rdata, // Read data, cycle after read strobe.
   input wire logic i_boot_reset_fuse, // Boot reset fuse, 0 programmed.
   input wire logic [7:0] i_fuse_low, // Fuse low byte.
   input wire logic [7:0] i_fuse_high, // Fuse high byte.
   input wire logic i_global_irq, // Global interrupt flag.
   input wire logic i_store_instr, // Store instruction executes.
   input wire logic i_load_instr, // Load instruction executes.
   input wire logic [7:0] i_pointer_low_byte, // Pointer low byte.
   input wire logic [7:0] i_pointer_high_byte, // Pointer high byte.
   input wire logic [7:0] i_data_low_register, // Data low register.
   input wire logic [7:0] i_data_high_register, // Data high register.
   input wire logic i_eeprom_busy, // Data-memory write in progress.
   input wire logic i_flash_done, // Flash array finished operation.
   output logic [16:0] o_reset_vector, // Reset vector word address.
   output logic o_ready_irq, // Ready interrupt request.
   output logic o_section_blocked, // Read-while-write section unreadable.
   output logic o_cpu_halt, // CPU halt while the no-read-while-write section is programmed.
   output flash_req_s o_flash_req, // Latched operation request.
   output logic o_flash_start, // One-cycle operation start pulse.
   output logic o_load_valid, // Load instruction result valid.
   output logic [7:0] o_load_data, // Lock or fuse byte for load.
   output logic [7:0] o_byte_addr_low, // Byte address low for ordinary loads.
   output logic o_byte_high // Pointer byte select for ordinary loads.
);
   logic [7:0] ctrl;
   logic [7:0] ext;
   logic [7:0] lock_bits;
   logic [2:0] window;
   logic busy_flag;
   logic running;
   logic loading;
   logic [15:0] page_buf [PAGE_WORDS];
   logic [PAGE_WORDS-1:0] buf_valid;
   logic [23:0] zptr;
   logic ctrl_wr;
   logic legal_pat;
   logic store_go;
   logic load_go;
   logic [16:0] word_addr;
   logic op_no_read_while_write_section;
   logic op_go;

   // Extension byte exists only for large program spaces.
   assign zptr = {(HAS_EXT ? ext : 8'h00), i_pointer_high_byte, i_pointer_low_byte};
   assign word_addr = zptr[17:1];
   assign op_no_read_while_write_section = (word_addr >= NO_READ_WHILE_WRITE_SECTION_START);
   // An erase or write that starts before the last window cycle keeps store enable up until the array is done.
   assign op_go = store_go && !i_eeprom_busy && (ctrl[4:0] == PAT_PER || ctrl[4:0] == PAT_PWR);
   assign ctrl_wr = i_wr && (i_addr == ADDR_CTRL) && !i_eeprom_busy;
   assign legal_pat = (i_wdata[4:0] == PAT_RD_EN) || (i_wdata[4:0] == PAT_LOCK) ||
                      (i_wdata[4:0] == PAT_PWR) || (i_wdata[4:0] == PAT_PER) ||
                      (i_wdata[4:0] == PAT_STORE);
   assign store_go = i_store_instr && ctrl[BIT_SEN] && !running && (window != 3'h0);
   assign load_go = i_load_instr && ctrl[BIT_SEN] && ctrl[BIT_LOCK] && !running &&
                    (window > (STORE_WINDOW - LOAD_WINDOW)) && !i_eeprom_busy;

   // Reset vector follows the fuse; no register path reaches the fuse.
   assign o_reset_vector = i_boot_reset_fuse ? {1'b0, APP_RESET_VECTOR} : BOOT_START;
   assign o_ready_irq = ctrl[BIT_IRQ_EN] && i_global_irq && !ctrl[BIT_SEN];
   assign o_section_blocked = busy_flag;
   assign o_cpu_halt = running && o_flash_req.no_read_while_write_section;
   assign o_byte_addr_low = zptr[7:0];
   assign o_byte_high = zptr[0];

   // Arming window counts cycles after the control write; expiry drops all command bits.
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         window <= 3'h0;
      end else if (ctrl_wr && legal_pat && !running) begin
         window <= STORE_WINDOW;
      end else if (store_go || load_go) begin
         window <= 3'h0;
      end else if (window != 3'h0) begin
         window <= window - 3'h1;
      end
   end

   // Control bits; store enable holds while an erase or write runs if it started before the last window cycle.
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ctrl <= CTRL_RESET;
      end else begin
         if (i_wr && i_addr == ADDR_CTRL) begin
            ctrl[BIT_IRQ_EN] <= i_wdata[BIT_IRQ_EN];
         end
         if (ctrl_wr && legal_pat && !running) begin
            ctrl[4:0] <= i_wdata[4:0];
         end else if (running) begin
            if (i_flash_done) begin
               ctrl[4:0] <= 5'h00;
            end
         end else if ((store_go && !op_go) || load_go || window == 3'h1) begin
            ctrl[4:0] <= 5'h00;
         end
      end
   end

   // Operation start: latch address and kind so later pointer changes do nothing.
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         running <= 1'b0;
         o_flash_start <= 1'b0;
         o_flash_req <= '0;
      end else begin
         o_flash_start <= 1'b0;
         if (running && i_flash_done) begin
            running <= 1'b0;
         end else if (store_go && !i_eeprom_busy) begin
            if (ctrl[4:0] == PAT_PER || ctrl[4:0] == PAT_PWR) begin
               running <= 1'b1;
               o_flash_start <= 1'b1;
               o_flash_req.op <= (ctrl[4:0] == PAT_PER) ? OP_ERASE : OP_WRITE;
               o_flash_req.page_addr <= {word_addr[16:WORD_BITS], {WORD_BITS{1'b0}}};
               o_flash_req.no_read_while_write_section <= op_no_read_while_write_section;
               o_flash_req.lock_data <= 8'h00;
            end else if (ctrl[4:0] == PAT_LOCK) begin
               o_flash_start <= 1'b1;
               o_flash_req.op <= OP_LOCK;
               o_flash_req.lock_data <= i_data_low_register;
            end
         end
      end
   end

   // Section busy flag: set by section programming, cleared by re-enable or page load.
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         busy_flag <= 1'b0;
      end else if (store_go && !i_eeprom_busy && !op_no_read_while_write_section &&
                   (ctrl[4:0] == PAT_PER || ctrl[4:0] == PAT_PWR)) begin
         busy_flag <= 1'b1;
      end else if (store_go && (ctrl[4:0] == PAT_RD_EN || ctrl[4:0] == PAT_STORE)) begin
         busy_flag <= 1'b0;
      end
   end

   // Boot lock bits 5 to 2: a zero in the data programs the bit, only reset would undo it.
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         lock_bits <= LOCK_RESET;
      end else if (store_go && !i_eeprom_busy && ctrl[4:0] == PAT_LOCK) begin
         lock_bits[5:2] <= lock_bits[5:2] & i_data_low_register[5:2];
      end
   end

   // Temporary page buffer; a word is written once until the buffer is erased.
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         buf_valid <= '0;
         loading <= 1'b0;
      end else if ((ctrl_wr && i_wdata[BIT_RD_EN]) ||
                   (o_flash_start && o_flash_req.op == OP_WRITE && running)) begin
         buf_valid <= '0;
         loading <= 1'b0;
      end else if (store_go && ctrl[4:0] == PAT_STORE && !i_eeprom_busy) begin
         buf_valid[word_addr[WORD_BITS-1:0]] <= 1'b1;
         loading <= 1'b1;
      end
   end

   // Buffer data array needs no reset; validity bits guard it.
   always_ff @(posedge i_core_clk) begin
      if (store_go && ctrl[4:0] == PAT_STORE && !i_eeprom_busy &&
          !buf_valid[word_addr[WORD_BITS-1:0]]) begin
         page_buf[word_addr[WORD_BITS-1:0]] <= {i_data_high_register, i_data_low_register};
      end
   end

   // Extension byte register.
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ext <= 8'h00;
      end else if (i_wr && i_addr == ADDR_EXT && HAS_EXT) begin
         ext <= i_wdata;
      end
   end

   // Lock or fuse read for a load inside the three-cycle window.
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_load_valid <= 1'b0;
         o_load_data <= 8'h00;
      end else begin
         o_load_valid <= load_go;
         if (load_go) begin
            // Pointer 3 picks the high fuse byte, 1 the lock bits and 0 the low fuse byte.
            o_load_data <= zptr[1] ? i_fuse_high : (zptr[0] ? lock_bits : i_fuse_low);
         end
      end
   end

   // Register reads; bit 5 of the control register is always zero.
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_rdata <= 8'h00;
      end else if (i_rd) begin
         unique case (i_addr)
            ADDR_CTRL: o_rdata <= {ctrl[BIT_IRQ_EN], busy_flag, 1'b0, ctrl[4:0]};
            ADDR_EXT: o_rdata <= HAS_EXT ? ext : 8'h00;
            ADDR_LOCK: o_rdata <= lock_bits;
            ADDR_STATUS: o_rdata <= {5'h00, loading, running, window != 3'h0};
            default: o_rdata <= 8'h00;
         endcase
      end else begin
         o_rdata <= 8'h00;
      end
   end
endmodule : flash_self_prog_control

//--- verification/flash_self_prog_checker.sv
`timescale 1ns/10ps
module flash_self_prog_checker
   import flash_self_prog_pkg::*;
#(
   parameter logic [16:0] BOOT_START = 17'h1e000 // Boot loader start.
) (
   input wire logic i_core_clk, // Clock.
   input wire logic i_rstn, // Reset.
   input wire logic [2:0] i_addr, // Address.
   input wire logic i_rd, // Read strobe.
   input wire logic [7:0] o_rdata, // Read data.
   input wire logic i_boot_reset_fuse, // Boot fuse.
   input wire logic [16:0] o_reset_vector, // Vector.
   input wire logic o_ready_irq, // Ready request.
   input wire logic i_global_irq, // Global flag.
   input wire logic i_store_instr, // Store.
   input wire logic i_load_instr, // Load.
   input wire logic o_flash_start, // Start pulse.
   input flash_req_s o_flash_req, // Request.
   input wire logic o_cpu_halt, // Halt.
   input wire logic o_section_blocked, // Blocked.
   input wire logic o_load_valid // Load valid.
);
   // All checks share the one core clock and its reset.
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rstn);
   a_vector_select: assert property (o_reset_vector ==
      (i_boot_reset_fuse ? 17'h00000 : BOOT_START)) else $error("reset vector wrong");
   a_reserved_zero: assert property ($past(i_rd) && $past(i_addr) == ADDR_CTRL
      |-> !o_rdata[5]) else $error("reserved bit read as one");
   a_irq_gated: assert property (o_ready_irq |-> i_global_irq)
      else $error("ready request without global flag");
   a_start_cause: assert property (o_flash_start |-> $past(i_store_instr))
      else $error("start without store");
   a_req_latched: assert property (!o_flash_start |-> $stable(o_flash_req))
      else $error("request moved while running");
   a_no_read_while_write_section_halt: assert property (o_flash_start && o_flash_req.no_read_while_write_section
      && o_flash_req.op != OP_LOCK |-> o_cpu_halt) else $error("no halt");
   a_rww_busy: assert property (o_flash_start && !o_flash_req.no_read_while_write_section
      && o_flash_req.op != OP_LOCK |-> o_section_blocked) else $error("not blocked");
   a_load_cause: assert property (o_load_valid |-> $past(i_load_instr))
      else $error("load result without load");
endmodule : flash_self_prog_checker
bind flash_self_prog_control flash_self_prog_checker #(.BOOT_START(BOOT_START)) checker_i (
   .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata),
   .i_boot_reset_fuse(i_boot_reset_fuse), .o_reset_vector(o_reset_vector),
   .o_ready_irq(o_ready_irq), .i_global_irq(i_global_irq), .i_store_instr(i_store_instr),
   .i_load_instr(i_load_instr), .o_flash_start(o_flash_start), .o_flash_req(o_flash_req),
   .o_cpu_halt(o_cpu_halt), .o_section_blocked(o_section_blocked), .o_load_valid(o_load_valid));

//--- verification/flash_array_model.sv
`timescale 1ns/10ps
module flash_array_model #(
   parameter int DELAY = 6 // Cycles an erase or write takes.
) (
   input wire logic i_clk, // Clock.
   input wire logic i_rstn, // Reset.
   input wire logic i_start, // Start pulse.
   output logic o_done // Done pulse.
);
   int cnt;
   // Real arrays take milliseconds; a short count keeps the run brief.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt <= 0;
         o_done <= 1'b0;
      end else begin
         o_done <= (cnt == 1);
         cnt <= i_start ? DELAY : (cnt > 0 ? cnt - 1 : 0);
      end
   end
endmodule : flash_array_model

//--- verification/test_flash_self_program_control.sv
`timescale 1ns/10ps
module test_flash_self_program_control;
   import flash_self_prog_pkg::*;
   logic clk = 0, rstn = 0, wr = 0, rd = 0, fuse = 1, gi = 0, st = 0, ld = 0, ee = 0, done;
   logic [2:0] addr = 0;
   logic [7:0] wd = 0, zl = 0, zh = 0, rdata, ldat, bl;
   logic [7:0] bad [4] = '{8'h07, 8'h1f, 8'h02, 8'h0d};
   logic [7:0] lz [3] = '{8'h01, 8'h00, 8'h03};
   logic [7:0] lx [3] = '{LOCK_RESET, 8'h5a, 8'hc3};
   logic [16:0] vec;
   logic irq, blk, halt, start, lv, bh;
   flash_req_s req, q;
   int n_fail = 0, checks = 0;
   flash_self_prog_control flash_self_prog_control_i (.i_core_clk(clk), .i_rstn(rstn),
      .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_boot_reset_fuse(fuse), .i_fuse_low(8'h5a), .i_fuse_high(8'hc3), .i_global_irq(gi),
      .i_store_instr(st), .i_load_instr(ld), .i_pointer_low_byte(zl),
      .i_pointer_high_byte(zh), .i_data_low_register(8'h12), .i_data_high_register(8'h34),
      .i_eeprom_busy(ee), .i_flash_done(done), .o_reset_vector(vec), .o_ready_irq(irq),
      .o_section_blocked(blk), .o_cpu_halt(halt), .o_flash_req(req), .o_flash_start(start),
      .o_load_valid(lv), .o_load_data(ldat), .o_byte_addr_low(bl), .o_byte_high(bh));
   flash_array_model #(.DELAY(6)) flash_array_model_i (.i_clk(clk), .i_rstn(rstn),
      .i_start(start), .o_done(done));
   // Free-running core clock, 40 ns period.
   initial begin
      forever #20 clk = ~clk;
   end
   task automatic results();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : results
   task automatic chk(input string nm, input logic [31:0] exp, got);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk("register", 32'(e), 32'(rdata));
   endtask : rd_reg
   // Issued straight after a control write, so it lands in the first window cycle.
   task automatic store();
      st <= 1'b1;
      @(posedge clk);
      st <= 1'b0;
      @(negedge clk);
   endtask : store
   // Bounded wait for the array; a hang ends the run as a failure.
   task automatic wait_done();
      for (int k = 0; k < 40 && done !== 1'b1; k++) begin
         @(negedge clk);
      end
      if (done !== 1'b1) begin
         n_fail++;
         results();
      end
      @(negedge clk);
   endtask : wait_done
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      rd_reg(ADDR_CTRL, CTRL_RESET);
      chk("vector", 32'(APP_RESET_VECTOR), 32'(vec));
      @(posedge clk);
      fuse <= 1'b0;
      @(negedge clk);
      chk("vector", 32'h1e000, 32'(vec));
      $display("test reset done");
      gi <= 1'b1;
      wr_reg(ADDR_CTRL, 8'h81);
      @(negedge clk);
      chk("irq", 0, 32'(irq));
      repeat (6) @(posedge clk);
      rd_reg(ADDR_CTRL, 8'h80);
      chk("irq", 1, 32'(irq));
      foreach (bad[i]) begin
         wr_reg(ADDR_CTRL, bad[i]);
         rd_reg(ADDR_CTRL, 8'h00);
      end
      ee <= 1'b1;
      wr_reg(ADDR_CTRL, 8'h01);
      rd_reg(ADDR_CTRL, 8'h00);
      ee <= 1'b0;
      $display("test arming done");
      zh <= 8'h10;
      wr_reg(ADDR_CTRL, 8'h03);
      store();
      q = req;
      chk("start", 1, 32'(start));
      chk("blocked", 1, 32'(blk));
      chk("halt", 0, 32'(halt));
      zh <= 8'h20;
      rd_reg(ADDR_CTRL, 8'h43);
      // Re-enable attempted while the erase runs must leave the section blocked.
      wr_reg(ADDR_CTRL, 8'h11);
      store();
      chk("blocked", 1, 32'(blk));
      wait_done();
      chk("request", 32'(q), 32'(req));
      rd_reg(ADDR_CTRL, 8'h40);
      wr_reg(ADDR_CTRL, 8'h01);
      store();
      chk("blocked", 0, 32'(blk));
      rd_reg(ADDR_CTRL, 8'h00);
      rd_reg(ADDR_STATUS, 8'h04);
      wr_reg(ADDR_CTRL, 8'h11);
      rd_reg(ADDR_STATUS, 8'h01);
      $display("test erase done");
      wr_reg(ADDR_EXT, 8'h03);
      zh <= 8'hc0;
      // The page is erased first, at the same address that the write then uses.
      wr_reg(ADDR_CTRL, 8'h03);
      store();
      chk("halt", 1, 32'(halt));
      wait_done();
      wr_reg(ADDR_CTRL, 8'h05);
      store();
      chk("halt", 1, 32'(halt));
      wait_done();
      chk("halt", 0, 32'(halt));
      zh <= 8'h10;
      wr_reg(ADDR_CTRL, 8'h03);
      store();
      wait_done();
      chk("blocked", 1, 32'(blk));
      wr_reg(ADDR_CTRL, 8'h11);
      store();
      chk("blocked", 0, 32'(blk));
      $display("test write done");
      zh <= 8'h00;
      foreach (lz[i]) begin
         zl <= lz[i];
         wr_reg(ADDR_CTRL, 8'h09);
         ld <= 1'b1;
         @(posedge clk);
         ld <= 1'b0;
         @(negedge clk);
         chk("load", 32'(lx[i]), 32'(ldat));
         chk("load valid", 1, 32'(lv));
         chk("byte high", 32'(lz[i][0]), 32'(bh));
         chk("byte low", 32'(lz[i]), 32'(bl));
      end
      // Low data 0x12 clears lock bits 5 and 3 and 2, leaving 0xd3.
      wr_reg(ADDR_CTRL, 8'h09);
      store();
      rd_reg(ADDR_LOCK, 8'hd3);
      $display("test lock read done");
      results();
   end
endmodule : test_flash_self_program_control
